// [verilog/ufis_top.v]
// fifo-mode interrupt, timeout and line status logic of a uart
// assumes receive/transmit shift paths outside; rclk_x16 is a 16x baud pin
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ufis_map.vh"
// Function
// - rx irq while fill reaches trigger level
// - ident shows rx data code likewise
// - line status outranks rx data
// - data ready set on push, cleared empty
// - timeout after four idle char times
// - second stop bit counted in delay
// - char times counted from receiver clock
// - one read clears fired timeout, restarts
// - push or read restarts timer
// - tx empty irq, cleared by write/ident read
// - accept up to sixteen tx writes
// - delay tx empty indication after a lone byte
// - first tx irq immediate after enable change
// - timeout ranks below rx data, above tx empty
// - polled mode per direction enable
// - errors reported without ident change
// - holding empty flag when tx fifo empty
// - transmitter empty needs shift empty too
// - fifo error flag for any bad entry
// - polled mode: no trigger or timeout
// - timeout sets ident bit 3 with 2
// - two-bit trigger select 1/4/8/14
// - rx enable also gates timeout
module ufis_top #(
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire        clk,
   input  wire        reset,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        rclk_x16,
   input  wire        rx_push,
   input  wire [7:0]  rx_char,
   input  wire [2:0]  rx_err,
   input  wire        tx_pop_req,
   input  wire        tx_shift_empty,
   input  wire        tx_stop_start,
   output reg         tx_valid,
   output reg  [7:0]  tx_char,
   output reg         irq
);
   reg  [10:0]   rxm [0:DEPTH-1];
   reg  [7:0]    txm [0:DEPTH-1];
   reg  [AW-1:0] rwp_q;
   reg  [AW-1:0] rrp_q;
   reg  [AW-1:0] twp_q;
   reg  [AW-1:0] trp_q;
   reg  [AW:0]   rcnt_q;
   reg  [AW:0]   tcnt_q;
   reg  [3:0]    ien_q;
   reg  [7:0]    fctl_q;
   reg  [3:0]    lctl_q;
   reg           oe_q;
   reg           lsr_q;
   reg           holding_empty_state_irq_q;
   reg           to_q;
   reg           seen2_q;
   reg           txdel_q;
   reg  [9:0]    chtick_q;
   reg  [2:0]    chcnt_q;
   reg  [9:0]    txdly_q;
   reg  [3:0]    ident_q;
   reg           rs1_q;
   reg           rs2_q;
   reg           rs3_q;
   reg           entry_bad;
   wire        acc  = psel & penable & pready;
   wire        wr   = acc & pwrite;
   wire        rd   = acc & ~pwrite;
   wire        fen  = fctl_q[0];
   wire        rd_data  = rd & (paddr == `UFIS_OFF_DATA) & (rcnt_q != 0);
   wire        wr_data  = wr & (paddr == `UFIS_OFF_DATA) & (tcnt_q != DEPTH);
   wire        rd_ident = rd & (paddr == `UFIS_OFF_IDENT);
   wire        rd_status = rd & (paddr == `UFIS_OFF_STATUS);
   wire        wr_fctl  = wr & (paddr == `UFIS_OFF_FIFOCTL);
   wire        push     = rx_push & (rcnt_q != DEPTH);
   wire        pop_tx   = tx_pop_req & (tcnt_q != 0) & ~tx_valid;
   wire        tick     = rs2_q & ~rs3_q;
   reg  [4:0]  trig;
   always @* begin
      case (fctl_q[7:6])
         2'b00:   trig = `UFIS_TRIG_L0;
         2'b01:   trig = `UFIS_TRIG_L1;
         2'b10:   trig = `UFIS_TRIG_L2;
         default: trig = `UFIS_TRIG_L3;
      endcase
   end
   // char length in x16 ticks: start+data(5..8)+parity+stop(s)
   wire [4:0]  nbits = 5'h07 + {3'h0, lctl_q[1:0]} + {4'h0, lctl_q[3]}
                       + {4'h0, lctl_q[2]};
   wire [9:0]  char_ticks = {1'b0, nbits, 4'h0};
   wire        rx_lvl  = fen & ien_q[0] & ({1'b0, rcnt_q} >= {1'b0, trig});
   wire        rx_to   = fen & ien_q[0] & to_q;
   wire        tx_lvl  = ien_q[1] & holding_empty_state_irq_q;
   wire        ls_lvl  = ien_q[2] & lsr_q;
   wire        rx_char_lvl = ~fen & ien_q[0] & (rcnt_q != 0);
   reg  [3:0]  id_d;
   always @* begin
      if (ls_lvl)                 id_d = `UFIS_ID_LINE;
      else if (rx_lvl | rx_char_lvl) id_d = `UFIS_ID_RXDATA;
      else if (rx_to)             id_d = `UFIS_ID_TIMEOUT;
      else if (tx_lvl)            id_d = `UFIS_ID_TXEMPTY;
      else                        id_d = `UFIS_ID_NONE;
   end
   // scans every slot so the flag drops by itself once the bad entry is read out
   integer i;
   always @* begin
      entry_bad = 1'b0;
      for (i = 0; i < DEPTH; i = i + 1) begin
         if (((i - rrp_q) & (DEPTH - 1)) < rcnt_q && rxm[i][10:8] != 3'h0) begin
            entry_bad = 1'b1;
         end
      end
   end
   always @(posedge clk) begin
      if (push)
         rxm[rwp_q] <= {rx_err, rx_char};
      if (wr_data)
         txm[twp_q] <= pwdata[7:0];
   end
   // receiver clock pin: two stages against metastability, a third for the edge
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
         rs3_q <= 1'b0;
      end else begin
         rs1_q <= rclk_x16;
         rs2_q <= rs1_q;
         rs3_q <= rs2_q;
      end
   end

   // no wait state: ready is registered from the setup cycle, which keeps the read mux off the address path
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~pready;
         pslverr <= 1'b0;
      end
   end

   // receive fifo pointers and fill level
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rwp_q  <= {AW{1'b0}};
         rrp_q  <= {AW{1'b0}};
         rcnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            rwp_q <= rwp_q + 1'b1;
         end
         if (rd_data) begin
            rrp_q <= rrp_q + 1'b1;
         end
         rcnt_q <= rcnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, rd_data};
      end
   end

   // transmit fifo; one character is offered to the shifter at a time
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         twp_q    <= {AW{1'b0}};
         trp_q    <= {AW{1'b0}};
         tcnt_q   <= {(AW+1){1'b0}};
         tx_valid <= 1'b0;
         tx_char  <= 8'h00;
      end else begin
         if (wr_data) begin
            twp_q <= twp_q + 1'b1;
         end
         if (pop_tx) begin
            trp_q    <= trp_q + 1'b1;
            tx_valid <= 1'b1;
            tx_char  <= txm[trp_q];
         end else if (tx_valid & tx_stop_start) begin
            tx_valid <= 1'b0;
         end
         tcnt_q <= tcnt_q + {{AW{1'b0}}, wr_data} - {{AW{1'b0}}, pop_tx};
      end
   end

   // overrun stays until status is read; a new overrun in that cycle wins
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         oe_q  <= 1'b0;
         lsr_q <= 1'b0;
      end else begin
         if (rx_push & ~push) begin
            oe_q <= 1'b1;
         end else if (rd_status) begin
            oe_q <= 1'b0;
         end
         lsr_q <= oe_q | entry_bad;
      end
   end

   // timeout timer in character times; idle while the receive fifo is empty
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         chtick_q <= 10'h000;
         chcnt_q  <= 3'h0;
         to_q     <= 1'b0;
      end else if (push | rd_data) begin
         chtick_q <= 10'h000;
         chcnt_q  <= 3'h0;
         to_q     <= 1'b0;
      end else if (rcnt_q == {(AW+1){1'b0}}) begin
         chtick_q <= 10'h000;
         chcnt_q  <= 3'h0;
         to_q     <= 1'b0;
      end else if (tick && !to_q) begin
         if (chtick_q == char_ticks - 10'h001) begin
            chtick_q <= 10'h000;
            if ({1'b0, chcnt_q} == `UFIS_TIMEOUT_CHARS - 4'h1) begin
               to_q <= 1'b1;
            end else begin
               chcnt_q <= chcnt_q + 3'h1;
            end
         end else begin
            chtick_q <= chtick_q + 10'h001;
         end
      end
   end

   // transmit empty: a lone byte holds the indication back until its
   // last stop bit starts, so software does not refill a busy line early
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         holding_empty_state_irq_q <= 1'b0;
         seen2_q    <= 1'b0;
         txdel_q    <= 1'b0;
         txdly_q    <= 10'h000;
      end else begin
         if (tcnt_q > {{AW{1'b0}}, 1'b1}) begin
            seen2_q <= 1'b1;
         end
         if (wr_fctl && pwdata[0] != fen) begin
            holding_empty_state_irq_q <= 1'b1;
            txdel_q    <= 1'b0;
            seen2_q    <= 1'b0;
         end else if (wr_data) begin
            holding_empty_state_irq_q <= 1'b0;
            txdel_q    <= 1'b0;
         end else if (pop_tx && tcnt_q == {{AW{1'b0}}, 1'b1}) begin
            if (fen && !seen2_q) begin
               txdel_q <= 1'b1;
               txdly_q <= char_ticks - 10'h010;
            end else begin
               holding_empty_state_irq_q <= 1'b1;
               seen2_q    <= 1'b0;
            end
         end else if (txdel_q && tick) begin
            if (txdly_q <= 10'h001) begin
               txdel_q    <= 1'b0;
               holding_empty_state_irq_q <= 1'b1;
               seen2_q    <= 1'b0;
            end else begin
               txdly_q <= txdly_q - 10'h001;
            end
         end else if (rd_ident && ident_q == `UFIS_ID_TXEMPTY) begin
            holding_empty_state_irq_q <= 1'b0;
         end
      end
   end

   // ident freezes only in the access cycle; the code shown is taken at the setup edge, one update before the code that the read clears
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ident_q <= `UFIS_ID_NONE;
         irq     <= 1'b0;
      end else begin
         if (!rd_ident) begin
            ident_q <= id_d;
         end
         irq <= (id_d != `UFIS_ID_NONE);
      end
   end

   // control registers; writes to unmapped offsets are dropped
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ien_q  <= 4'h0;
         fctl_q <= 8'h00;
         lctl_q <= 4'h0;
      end else if (wr) begin
         case (paddr)
            `UFIS_OFF_IRQEN: begin
               ien_q <= pwdata[3:0];
            end
            `UFIS_OFF_FIFOCTL: begin
               fctl_q <= {pwdata[7:6], 5'h00, pwdata[0]};
            end
            `UFIS_OFF_LINECTL: begin
               lctl_q <= pwdata[3:0];
            end
            default: begin
               lctl_q <= lctl_q;
            end
         endcase
      end
   end

   // read data is taken at the setup edge and stands until the next access
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~pready) begin
         case (paddr)
            `UFIS_OFF_DATA:    prdata <= {21'h0, rxm[rrp_q]};
            `UFIS_OFF_IRQEN:   prdata <= {28'h0, ien_q};
            `UFIS_OFF_IDENT:   prdata <= {24'h0, {2{fen}}, 2'b00, ident_q};
            `UFIS_OFF_FIFOCTL: prdata <= {24'h0, fctl_q};
            `UFIS_OFF_LINECTL: prdata <= {28'h0, lctl_q};
            `UFIS_OFF_STATUS: begin
               prdata <= {24'h0, entry_bad,
                  (tcnt_q == {(AW+1){1'b0}}) & ~txdel_q & tx_shift_empty & ~tx_valid,
                  (tcnt_q == {(AW+1){1'b0}}) & ~txdel_q,
                  1'b0, 2'b00, oe_q, rcnt_q != {(AW+1){1'b0}}};
            end
            `UFIS_OFF_LEVEL:   prdata <= {16'h0, 3'h0, tcnt_q, 3'h0, rcnt_q};
            default:           prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// [verilog/ufis_map.vh]
// register map and constants of the fifo interrupt and status block
// assumes a 32-bit apb slave, one aligned word per register
`ifndef UFIS_MAP_VH
`define UFIS_MAP_VH
`define UFIS_OFF_DATA      12'h000
`define UFIS_OFF_IRQEN     12'h004
`define UFIS_OFF_IDENT     12'h008
`define UFIS_OFF_FIFOCTL   12'h00C
`define UFIS_OFF_LINECTL   12'h010
`define UFIS_OFF_STATUS    12'h014
`define UFIS_OFF_LEVEL     12'h018
`define UFIS_ID_NONE       4'h1
`define UFIS_ID_LINE       4'h6
`define UFIS_ID_RXDATA     4'h4
`define UFIS_ID_TIMEOUT    4'hC
`define UFIS_ID_TXEMPTY    4'h2
`define UFIS_TRIG_L0       5'h01
`define UFIS_TRIG_L1       5'h04
`define UFIS_TRIG_L2       5'h08
`define UFIS_TRIG_L3       5'h0E
`define UFIS_TIMEOUT_CHARS 4'h4
`define UFIS_BIT_TICKS     5'h10
`endif

// [verification/ufis_checker.sv]
// bus-side assertions of the fifo status block
// assumes one clock domain, reset async active high
`timescale 1ns/10ps
`default_nettype none
`include "ufis_map.vh"
module ufis_checker (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire rd_ok = pready && !pwrite;
   property p_wait; psel && !penable |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("no answer after setup");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_ack; pready |-> psel && penable; endproperty
   a_ack: assert property (p_ack) else $error("ready outside access");
   property p_err; !pslverr; endproperty
   a_err: assert property (p_err) else $error("slave error raised");
   property p_hold; !pready |-> $stable(prdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_code; rd_ok && paddr == `UFIS_OFF_IDENT |->
      prdata[5:4] == 2'h0 && prdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2}; endproperty
   a_code: assert property (p_code) else $error("bad ident code");
   property p_temt; rd_ok && paddr == `UFIS_OFF_STATUS && prdata[6] |-> prdata[5]; endproperty
   a_temt: assert property (p_temt) else $error("empty without holding empty");
   property p_ferr; rd_ok && paddr == `UFIS_OFF_STATUS && prdata[7] |-> prdata[0]; endproperty
   a_ferr: assert property (p_ferr) else $error("fifo error with empty fifo");
endmodule
bind ufis_top ufis_checker u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [verification/ufis_line_model.sv]
// far-side model: receiver clock pin and a transmit shifter that drains on request
// assumes clk from the bench; one receiver tick every two clocks
`timescale 1ns/10ps
`default_nettype none
module ufis_line_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic drain,
   input  wire logic tx_valid,
   output var  logic rclk_x16,
   output wire logic tx_pop_req,
   output wire logic tx_shift_empty,
   output wire logic tx_stop_start
);
   // shifter asks only while the bench drains; last stop bit after eight cycles
   logic [3:0] sh_cnt_q;
   assign tx_pop_req     = drain;
   assign tx_shift_empty = ~tx_valid;
   assign tx_stop_start  = tx_valid && sh_cnt_q == 4'h8;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         sh_cnt_q <= 4'h0;
      end else begin
         sh_cnt_q <= tx_valid ? sh_cnt_q + 4'h1 : 4'h0;
      end
   end
   always @(posedge clk or posedge reset) rclk_x16 <= reset ? 1'b0 : ~rclk_x16;
endmodule
`default_nettype wire

// [verification/tb_ufis_top.sv]
// self-checking bench of the fifo status block
// assumes the line model for the far side and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "ufis_map.vh"
module tb_ufis_top;
   logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, rx_push = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [7:0]  rx_char = 0, tx_char;
   logic [2:0]  rx_err = 0;
   logic        drain = 0;
   logic        pready, pslverr, rclk, pop, sh_empty, stop_go, tx_valid, irq;
   int          errors = 0, n_compared = 0, n;
   time         t0;
   always #5 clk = ~clk;
   ufis_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rclk_x16(rclk), .rx_push(rx_push), .rx_char(rx_char), .rx_err(rx_err),
      .tx_pop_req(pop), .tx_shift_empty(sh_empty), .tx_stop_start(stop_go),
      .tx_valid(tx_valid), .tx_char(tx_char), .irq(irq));
   ufis_line_model line (.clk(clk), .reset(reset), .drain(drain), .tx_valid(tx_valid),
      .rclk_x16(rclk), .tx_pop_req(pop),
      .tx_shift_empty(sh_empty), .tx_stop_start(stop_go));
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one apb transfer; waits for ready under a bound
   task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
      @(posedge clk);
      penable <= 1;
      k = 0;
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin errors++; finish_test(); end
      rd = prdata;
      psel <= 0; penable <= 0;
   endtask
   task automatic push(int k);
      repeat (k) begin
         @(posedge clk); rx_push <= 1; rx_char <= rx_char + 8'h01;
         @(posedge clk); rx_push <= 0;
      end
   endtask
   task automatic test_trigger;
      bus(1, `UFIS_OFF_FIFOCTL, 32'h41); // level four
      bus(1, `UFIS_OFF_IRQEN, 32'h1);
      push(3);
      bus(0, `UFIS_OFF_IDENT, 0); check("ident below", rd, 32'hC1);
      check("irq below", irq, 1'b0);
      push(1);
      bus(0, `UFIS_OFF_IDENT, 0); check("ident at level", rd, 32'hC4);
      check("irq at level", irq, 1'b1);
      bus(0, `UFIS_OFF_STATUS, 0); check("status", rd, 32'h61);
      bus(0, `UFIS_OFF_DATA, 0); check("first char", rd[7:0], 8'h01);
      t0 = $time;
      bus(0, `UFIS_OFF_IDENT, 0); check("ident dropped", rd, 32'hC1);
      $display("test trigger done");
   endtask
   task automatic test_timeout;
      n = 0;
      do begin bus(0, `UFIS_OFF_IDENT, 0); n++; end while (rd[3:0] !== 4'hC && n < 1000);
      check("ident timeout", rd, 32'hCC);
      if (rd[3:0] !== 4'hC) finish_test();
      // four chars of seven bits at sixteen ticks, one tick per two clocks
      check("not early", ($time - t0) >= 8960, 1);
      bus(0, `UFIS_OFF_DATA, 0); check("second char", rd[7:0], 8'h02);
      bus(0, `UFIS_OFF_IDENT, 0); check("timeout cleared", rd, 32'hC1);
      $display("test timeout done");
   endtask
   task automatic test_tx_polled;
      bus(1, `UFIS_OFF_IRQEN, 32'h2);
      bus(0, `UFIS_OFF_IDENT, 0); check("tx empty code", rd, 32'hC2);
      bus(0, `UFIS_OFF_IDENT, 0); check("cleared by read", rd, 32'hC1);
      bus(1, `UFIS_OFF_DATA, 32'h5A);
      bus(0, `UFIS_OFF_STATUS, 0); check("tx not empty", rd, 32'h01);
      bus(1, `UFIS_OFF_IRQEN, 32'h0);
      push(2);
      bus(0, `UFIS_OFF_IDENT, 0); check("polled ident", rd, 32'hC1);
      check("polled irq", irq, 1'b0);
      bus(0, `UFIS_OFF_LEVEL, 0); check("levels", rd, 32'h104);
      bus(0, 12'h0FC, 0); check("unmapped", rd, 32'h0);
      $display("test tx and polled done");
   endtask
   task automatic test_drain;
      drain <= 1;
      n = 0;
      do begin @(posedge clk); n++; end while (tx_valid !== 1'b1 && n < 20);
      if (tx_valid !== 1'b1) begin errors++; finish_test(); end
      t0 = $time;
      check("tx char", tx_char, 32'h5A);
      bus(0, `UFIS_OFF_STATUS, 0); check("empty held back", rd, 32'h01);
      bus(1, `UFIS_OFF_IRQEN, 32'h2);
      n = 0;
      do begin bus(0, `UFIS_OFF_IDENT, 0); n++; end while (rd[3:0] !== 4'h2 && n < 200);
      check("tx empty after delay", rd, 32'hC2);
      if (rd[3:0] !== 4'h2) finish_test();
      // six bit times of sixteen ticks, a tick per two clocks, less sync slack
      check("delay kept", ($time - t0) >= 1900, 1);
      check("tx released", tx_valid, 1'b0);
      bus(0, `UFIS_OFF_STATUS, 0); check("all empty", rd, 32'h61);
      $display("test drain done");
   endtask
   task automatic test_errors;
      rx_err <= 3'h4;
      push(1);
      rx_err <= 3'h0;
      bus(1, `UFIS_OFF_IRQEN, 32'h5);
      bus(0, `UFIS_OFF_IDENT, 0); check("line over data", rd, 32'hC6);
      check("line irq", irq, 1'b1);
      bus(1, `UFIS_OFF_IRQEN, 32'h0);
      bus(0, `UFIS_OFF_IDENT, 0); check("polled errors", rd, 32'hC1);
      bus(0, `UFIS_OFF_STATUS, 0); check("fifo error", rd, 32'hE1);
      $display("test errors done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      reset <= 0;
      test_trigger();
      test_timeout();
      test_tx_polled();
      test_drain();
      test_errors();
      finish_test();
   end
endmodule
`default_nettype wire
